// ==== logic/cmc_pkg.sv ====
// Shared constants for the class-of-service cache mask control block
package cmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 64;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [11:0] ASSOC_ADDR     = 12'hC8F;  // thread_class_assoc_reg
    localparam logic [11:0] SPLIT_CFG_ADDR = 12'hC81;  // l3_split_config_reg
    localparam logic [11:0] MASK_BASE_ADDR = 12'hC90;  // l3_capacity_mask_0

    ////////////////////////////////////////////////////////////////////////
    // Field layouts
    localparam int unsigned CLASS_LSB     = 32;  // service_class_field low bit
    localparam int unsigned CLASS_W       = 32;  // service_class_field width
    localparam int unsigned SPLIT_EN_BIT  = 0;   // code_data_split enable
    localparam int unsigned CAP_FIELD_W   = 16;  // largest class capability field

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] CLASS_RESET    = 32'h0000_0000;
    localparam logic        SPLIT_RESET    = 1'b0;
    localparam logic [15:0] FAULT_CODE     = 16'h0000;  // general_protection_fault code

endpackage

// ==== logic/reset_sync.sv ====
// Two-stage release synchroniser for the asynchronous active-low reset
module reset_sync (
    // Clock and raw reset
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // Synchronised reset
    output logic      rst_n_o
);

    logic [1:0] sync_q;
    logic [1:0] sync_d;

    // Shift a one in behind the release; assertion stays asynchronous
    always_comb begin
        sync_d = {sync_q[0], 1'b1};
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_q <= 2'h0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign rst_n_o = sync_q[1];

endmodule

// ==== logic/mask_store.sv ====
// Capacity mask array with one write port and two read ports
module mask_store #(
    parameter int unsigned N     = 16,
    parameter int unsigned W     = 16,
    parameter int unsigned IDX_W = 4
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [IDX_W-1:0] widx_i,
    input  wire logic [W-1:0]     wdata_i,
    // Register read port
    input  wire logic [IDX_W-1:0] ridx_a_i,
    output logic      [W-1:0]     rdata_a_o,
    // Fill lookup port
    input  wire logic [IDX_W-1:0] ridx_b_i,
    output logic      [W-1:0]     rdata_b_o
);

    logic [W-1:0] mask_q [N];
    logic [W-1:0] mask_d [N];

    // Only the bus write changes a mask; idle, power and interrupt events never do
    always_comb begin
        mask_d = mask_q;
        if (we_i && (32'(widx_i) < N)) begin
            mask_d[widx_i] = wdata_i;
        end
    end

    // Every mask opens the whole cache after reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                mask_q[i] <= '1;
            end
        end else begin
            mask_q <= mask_d;
        end
    end

    // Out-of-range indices read zero on the register port and all ones on the fill port
    assign rdata_a_o = (32'(ridx_a_i) < N) ? mask_q[ridx_a_i] : '0;
    assign rdata_b_o = (32'(ridx_b_i) < N) ? mask_q[ridx_b_i] : '1;

endmodule

// ==== logic/cache_class_mask_control.sv ====
// Class-of-service association and capacity mask control for cache fills
//
// Chosen here: strobed register access and the address map.

// Notes on behaviour
// R1: Writes changing reserved bits raise a general protection fault, code zero.
// R2: Any mask access above the enumerated class maximum faults.
// R3: Writing a class above the largest maximum of all resources faults.
// R4: Reading the association register returns the thread's current class.
// R5: Reading mask n returns the mask currently held for entry n.
// R6: All registers are readable and writable at any time, no quiescing.
// R7: Software uses only lower-half classes while split mode is on.
// R8: Association contents survive deep idle state entry and exit.
// R9: Mask contents survive package idle entry and exit.
// R10: System management interrupt delivery leaves association and masks unchanged.
// R11: Powered-off cache portions ignore the masks; power control wins.
// R12: After power-up new fills follow the masks; old lines may be gone.
// R13: Shared mode maps each class to one mask for code and data.
// R14: Split mode gives each class a code mask and a data mask.
// R15: Software writes all ones to every mask before toggling split mode.
// R16: Software checks only split-valid classes are used before enabling.
// R17: Software moves all threads to class zero before toggling split mode.
// R18: A class number means the same in both modes; only mapping changes.
// R19: A management handler may switch to a reserved class and back.
// R20: Split mode: data mask at index 2n, code mask at 2n plus one.
// R21: Config bit 0 enables split mode; setting bits 63:1 faults.
// R22: Reset clears config to zero and sets every mask to all ones.
// R23: The class field sits in bits 63:32 of the association register.
// R24: Each fill picks the thread's class mask, code or data in split mode.
module cache_class_mask_control #(
    parameter int unsigned NUM_THREADS   = 2,
    parameter int unsigned NUM_CLASSES   = 16,
    parameter int unsigned OTHER_CLASSES = 16,
    parameter int unsigned MASK_W        = 16,
    // Thread index width follows the thread count; not for override
    localparam int unsigned TID_W        = (NUM_THREADS > 1) ? $clog2(NUM_THREADS) : 1
) (
    // Clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      resetn_i,
    // Register port
    input  wire logic [cmc_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [cmc_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    input  wire logic [TID_W-1:0]          reg_thread_i,
    output logic      [cmc_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                           gp_fault_o,
    output logic      [15:0]               fault_code_o,
    // Capability
    output logic      [15:0]               cap_max_class_o,
    // Power and mode events
    input  wire logic                      deep_idle_i,
    input  wire logic                      pkg_idle_i,
    input  wire logic                      smi_i,
    input  wire logic [MASK_W-1:0]         ways_off_i,
    // Cache fill request
    input  wire logic                      fill_req_i,
    input  wire logic [TID_W-1:0]          fill_thread_i,
    input  wire logic                      fill_code_i,
    // Cache fill answer
    output logic                           fill_valid_o,
    output logic      [MASK_W-1:0]         fill_ways_o,
    // Mode status
    output logic                           split_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // Derived sizes
    // One store entry per class; split mode only re-indexes them
    localparam int unsigned IDX_W = (NUM_CLASSES > 1) ? $clog2(NUM_CLASSES) : 1;
    localparam int unsigned ALL_CLASSES =
        (NUM_CLASSES > OTHER_CLASSES) ? NUM_CLASSES : OTHER_CLASSES;
    // Largest class of this cache, as the capability field shows
    localparam logic [15:0] L3_MAX  = 16'(NUM_CLASSES - 1);
    // Largest class of any resource; the association accepts it
    // even where this cache holds no mask for it
    localparam logic [31:0] ALL_MAX = 32'(ALL_CLASSES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    // Entry is asynchronous; exit waits two edges so that no
    // flop sees the release close to a clock edge
    logic rst_n;

    reset_sync u_reset_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .rst_n_o  (rst_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Architectural state
    // One class per thread; the split flag is shared by all threads
    logic [cmc_pkg::CLASS_W-1:0] class_q [NUM_THREADS];
    logic [cmc_pkg::CLASS_W-1:0] class_d [NUM_THREADS];
    logic                        split_q;
    logic                        split_d;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    // One port serves all threads; reg_thread_i picks the copy
    logic [cmc_pkg::ADDR_W-1:0] mask_off;
    logic                       hit_assoc;
    logic                       hit_cfg;
    logic                       hit_mask_rng;
    logic                       mask_in_cap;

    // Mask window starts at the base; its length follows the class count.
    // Below the base the offset wraps, so it only counts together
    // with the range test.
    always_comb begin
        mask_off     = reg_addr_i - cmc_pkg::MASK_BASE_ADDR;
        hit_assoc    = (reg_addr_i == cmc_pkg::ASSOC_ADDR);
        hit_cfg      = (reg_addr_i == cmc_pkg::SPLIT_CFG_ADDR);
        hit_mask_rng = (reg_addr_i >= cmc_pkg::MASK_BASE_ADDR);
        mask_in_cap  = hit_mask_rng && ({4'h0, mask_off} <= L3_MAX); // [R2]
    end

    ////////////////////////////////////////////////////////////////////////
    // Write checks
    logic [cmc_pkg::CLASS_W-1:0] wr_class;
    logic                        assoc_bad;
    logic                        cfg_bad;
    logic                        mask_bad;
    logic                        wr_fault;
    logic                        rd_fault;
    logic                        wr_ok;

    // A faulting write leaves every register as it was.
    // Mask bits above MASK_W have no ways behind them: reserved.
    always_comb begin
        wr_class  = reg_wdata_i[cmc_pkg::CLASS_LSB +: cmc_pkg::CLASS_W]; // [R23]
        // Low half is reserved here; any set bit is a change from zero
        assoc_bad = (reg_wdata_i[cmc_pkg::CLASS_LSB-1:0] != '0) // [R1]
                  || (wr_class > ALL_MAX);                        // [R3]
        cfg_bad   = (reg_wdata_i[cmc_pkg::DATA_W-1:1] != '0);     // [R21]
        mask_bad  = (reg_wdata_i[cmc_pkg::DATA_W-1:MASK_W] != '0) // [R1]
                  || !mask_in_cap;                                // [R2]
        if (hit_assoc) begin
            wr_fault = assoc_bad;
        end else if (hit_cfg) begin
            wr_fault = cfg_bad;
        end else if (hit_mask_rng) begin
            wr_fault = mask_bad;
        end else begin
            // Nothing lives here; a silent drop would hide bugs
            wr_fault = 1'b1;
        end
        // Reads fault only on an address that holds nothing
        rd_fault = !(hit_assoc || hit_cfg || mask_in_cap);        // [R2]
        wr_ok    = reg_wr_i && !wr_fault;                          // [R6]
    end

    ////////////////////////////////////////////////////////////////////////
    // Association and configuration next state
    // Idle and interrupt inputs are deliberately absent: state rides through them
    always_comb begin
        class_d = class_q;                                  // [R8] [R10]
        split_d = split_q;
        // Only the addressed thread moves
        if (wr_ok && hit_assoc) begin
            class_d[reg_thread_i] = wr_class;
        end
        // One write re-maps every thread at once
        if (wr_ok && hit_cfg) begin
            split_d = reg_wdata_i[cmc_pkg::SPLIT_EN_BIT];   // [R21]
        end
    end

    // Everything starts in class zero with split mode off
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_THREADS; i++) begin
                class_q[i] <= cmc_pkg::CLASS_RESET;     // [R22]
            end
            split_q <= cmc_pkg::SPLIT_RESET;            // [R22]
        end else begin
            class_q <= class_d;
            split_q <= split_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask array
    logic [IDX_W-1:0]  fill_idx;
    logic [MASK_W-1:0] reg_mask;
    logic [MASK_W-1:0] fill_mask_raw;

    // Masks are only touched by bus writes, so idle and interrupt pass freely.
    // Port a serves reads, port b serves fills: they never wait on
    // each other. Faulting writes never reach the store.
    mask_store #(
        .N     (NUM_CLASSES),
        .W     (MASK_W),
        .IDX_W (IDX_W)
    ) u_mask_store (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n),
        .we_i      (wr_ok && hit_mask_rng),              // [R9] [R10]
        .widx_i    (mask_off[IDX_W-1:0]),
        .wdata_i   (reg_wdata_i[MASK_W-1:0]),
        .ridx_a_i  (mask_off[IDX_W-1:0]),
        .rdata_a_o (reg_mask),
        .ridx_b_i  (fill_idx),
        .rdata_b_o (fill_mask_raw)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data and fault answer
    logic [cmc_pkg::DATA_W-1:0] rdata_q;
    logic [cmc_pkg::DATA_W-1:0] rdata_d;
    logic                       fault_q;
    logic                       fault_d;

    // Read data stands for exactly one cycle, zero otherwise.
    // A faulting read returns zero so no stale mask leaks out.
    always_comb begin
        rdata_d = '0;
        if (reg_rd_i && !rd_fault) begin
            if (hit_assoc) begin
                rdata_d[cmc_pkg::CLASS_LSB +: cmc_pkg::CLASS_W] =
                    class_q[reg_thread_i];                         // [R4]
            end else if (hit_cfg) begin
                // Only the enable bit exists; the rest reads zero
                rdata_d[cmc_pkg::SPLIT_EN_BIT] = split_q;
            end else begin
                rdata_d[MASK_W-1:0] = reg_mask;                    // [R5]
            end
        end
        fault_d = (reg_wr_i && wr_fault) || (reg_rd_i && rd_fault); // [R1]
    end

    // Answer flops: one cycle behind the strobe
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
            fault_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            fault_q <= fault_d;
        end
    end

    // Data outputs come straight from flops
    assign reg_rdata_o  = rdata_q;
    assign gp_fault_o   = fault_q;
    assign fault_code_o = cmc_pkg::FAULT_CODE;                    // [R1]

    ////////////////////////////////////////////////////////////////////////
    // Fill mask selection
    logic [cmc_pkg::CLASS_W-1:0] fill_class;
    logic [cmc_pkg::CLASS_W:0]   fill_wide;
    logic                        fill_in_rng;
    logic [MASK_W-1:0]           fill_mask;
    logic                        fvalid_q;
    logic                        fvalid_d;
    logic [MASK_W-1:0]           fways_q;
    logic [MASK_W-1:0]           fways_d;

    // Class meaning never changes; only the mask index does.
    // Split mode: data at the even index, code at the odd one.
    // Upper-half classes then land beyond the store and get all
    // ways; software keeps out of them, so fills never fault.
    always_comb begin
        fill_class = class_q[fill_thread_i];                          // [R24] [R18]
        if (split_q) begin
            fill_wide = {fill_class, fill_code_i};                    // [R14] [R20]
        end else begin
            fill_wide = {1'b0, fill_class};                           // [R13]
        end
        // Full-width compare so no high class bit is lost
        fill_in_rng = (fill_wide <= 33'(L3_MAX));
        fill_idx    = fill_wide[IDX_W-1:0];
        // A class beyond this cache's masks is left unrestricted
        fill_mask   = fill_in_rng ? fill_mask_raw : '1;
        fvalid_d    = fill_req_i;
        // Powered-off ways are never offered, whatever the mask says
        fways_d     = fill_req_i ? (fill_mask & ~ways_off_i) : '0;   // [R11] [R12]
    end

    // No backpressure: each request is answered one cycle later
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            fvalid_q <= 1'b0;
            fways_q  <= '0;
        end else begin
            fvalid_q <= fvalid_d;
            fways_q  <= fways_d;
        end
    end

    // Fill answer, mode status and fixed capability
    assign fill_valid_o    = fvalid_q;
    assign fill_ways_o     = fways_q;
    assign split_en_o      = split_q;
    assign cap_max_class_o = L3_MAX;                              // [R2]

    // deep_idle_i, pkg_idle_i and smi_i need no logic: nothing here loses state.
    // All state sits in flops that stay powered through idle, and
    // an interrupt has no path into them. A cache that powers them
    // down would need a save and restore here.

endmodule

// ==== bench/cmc_chk.sv ====
// Concurrent checks on the ports of the cache class mask control block
module cmc_chk #(
    parameter int unsigned NUM_CLASSES   = 16,
    parameter int unsigned OTHER_CLASSES = 16,
    parameter int unsigned MASK_W        = 16
) (
    // Clock and reset
    input wire logic                       mclk_i,
    input wire logic                       resetn_i,
    // Register port
    input wire logic [cmc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [cmc_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [cmc_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic                       gp_fault_o,
    input wire logic [15:0]                fault_code_o,
    input wire logic [15:0]                cap_max_class_o,
    // Fill side
    input wire logic [MASK_W-1:0]          ways_off_i,
    input wire logic                       fill_req_i,
    input wire logic                       fill_valid_o,
    input wire logic [MASK_W-1:0]          fill_ways_o,
    input wire logic                       split_en_o
);
    localparam int unsigned CMAX = ((NUM_CLASSES > OTHER_CLASSES) ? NUM_CLASSES : OTHER_CLASSES) - 1;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // Address decode, kept apart from the design's own decode
    logic cfg_sel;
    logic assoc_wr;
    logic mask_oob;
    assign cfg_sel  = reg_addr_i == cmc_pkg::SPLIT_CFG_ADDR;
    assign assoc_wr = reg_wr_i && reg_addr_i == cmc_pkg::ASSOC_ADDR;
    assign mask_oob = (reg_wr_i || reg_rd_i) && reg_addr_i >= cmc_pkg::MASK_BASE_ADDR + NUM_CLASSES;

    sequence cfg_bad_s;
        reg_wr_i && cfg_sel && reg_wdata_i[63:1] != '0;
    endsequence
    sequence cfg_good_s;
        reg_wr_i && cfg_sel && reg_wdata_i[63:1] == '0;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Register side
    cfg_fault_a: assert property (cfg_bad_s |=> gp_fault_o && split_en_o == $past(split_en_o))
        else $error("config reserved write not refused");
    cfg_set_a: assert property (cfg_good_s |=> !gp_fault_o && split_en_o == $past(reg_wdata_i[0]))
        else $error("split enable not taken from bit 0");
    split_keep_a: assert property (!(reg_wr_i && cfg_sel) |=> $stable(split_en_o))
        else $error("split enable moved without a write");
    mask_range_a: assert property (mask_oob |=> gp_fault_o)
        else $error("mask index above class count not refused");
    assoc_range_a: assert property (assoc_wr && reg_wdata_i[63:32] > CMAX |=> gp_fault_o)
        else $error("class above maximum not refused");
    assoc_low_a: assert property (assoc_wr && reg_wdata_i[31:0] != '0 |=> gp_fault_o)
        else $error("reserved association bits not refused");
    quiet_bus_a: assert property (!reg_wr_i && !reg_rd_i |=> !gp_fault_o && reg_rdata_o == '0)
        else $error("fault or read data without an access");
    const_out_a: assert property (fault_code_o == cmc_pkg::FAULT_CODE
        && cap_max_class_o == 16'(NUM_CLASSES - 1))
        else $error("fault code or class capability wrong");

    ////////////////////////////////////////////////////////////////////////
    // Fill side
    fill_answer_a: assert property (fill_req_i |=> fill_valid_o
        && (fill_ways_o & $past(ways_off_i)) == '0)
        else $error("fill answer missing or uses powered-off ways");
    fill_idle_a: assert property (!fill_req_i |=> !fill_valid_o && fill_ways_o == '0)
        else $error("fill answer without a request");
endmodule

bind cache_class_mask_control cmc_chk #(
    .NUM_CLASSES  (NUM_CLASSES),
    .OTHER_CLASSES(OTHER_CLASSES),
    .MASK_W       (MASK_W)
) chk (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gp_fault_o(gp_fault_o),
    .fault_code_o(fault_code_o), .cap_max_class_o(cap_max_class_o), .ways_off_i(ways_off_i),
    .fill_req_i(fill_req_i), .fill_valid_o(fill_valid_o), .fill_ways_o(fill_ways_o), .split_en_o(split_en_o)
);

// ==== bench/core_model.sv ====
// Core-side model that issues cache fill requests
module core_model (
    // Clock
    input  wire logic mclk_i,
    // Fill request
    output logic       fill_req_o,
    output logic [0:0] fill_thread_o,
    output logic       fill_code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fill_req_o    = 1'b0;
        fill_thread_o = 1'b0;
        fill_code_o   = 1'b0;
    end
    // One fill per call; qualifiers are inverted afterwards so stale values are never trusted
    task automatic issue(input logic [0:0] th, input logic code);
        @(posedge mclk_i);
        fill_req_o    <= 1'b1;
        fill_thread_o <= th;
        fill_code_o   <= code;
        @(posedge mclk_i);
        fill_req_o    <= 1'b0;
        fill_thread_o <= ~th;
        fill_code_o   <= ~code;
    endtask
endmodule

// ==== bench/tb.sv ====
// Register and fill sequence testbench for the cache class mask control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NC = 8;
    localparam logic [11:0] MB = cmc_pkg::MASK_BASE_ADDR;
    localparam logic [11:0] AS = cmc_pkg::ASSOC_ADDR;
    localparam logic [11:0] CF = cmc_pkg::SPLIT_CFG_ADDR;
    logic mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, gp_fault_o, fill_valid_o, split_en_o;
    logic deep_idle_i = 1'b0, pkg_idle_i = 1'b0, smi_i = 1'b0, fill_req_i, fill_code_i;
    logic [11:0] reg_addr_i = 12'h000;
    logic [63:0] reg_wdata_i = 64'h0, reg_rdata_o;
    logic [0:0]  reg_thread_i = 1'b0, fill_thread_i, th = 1'b0;
    logic [15:0] fault_code_o, cap_max_class_o, fill_ways_o, ways_off_i = 16'h0000;
    int err_count = 0, num_checks = 0;

    cache_class_mask_control #(.NUM_THREADS(2), .NUM_CLASSES(NC), .OTHER_CLASSES(16), .MASK_W(16)) uut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_thread_i(reg_thread_i), .reg_rdata_o(reg_rdata_o),
        .gp_fault_o(gp_fault_o), .fault_code_o(fault_code_o), .cap_max_class_o(cap_max_class_o),
        .deep_idle_i(deep_idle_i), .pkg_idle_i(pkg_idle_i), .smi_i(smi_i), .ways_off_i(ways_off_i),
        .fill_req_i(fill_req_i), .fill_thread_i(fill_thread_i), .fill_code_i(fill_code_i),
        .fill_valid_o(fill_valid_o), .fill_ways_o(fill_ways_o), .split_en_o(split_en_o));
    core_model core (.mclk_i(mclk_i), .fill_req_o(fill_req_i), .fill_thread_o(fill_thread_i),
        .fill_code_o(fill_code_i));

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, access and verdict tasks
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One strobe cycle; the answer stands only in the following cycle
    task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d, output logic [63:0] r,
                       output logic f);
        @(posedge mclk_i);
        reg_wr_i     <= w;
        reg_rd_i     <= !w;
        reg_addr_i   <= a;
        reg_wdata_i  <= d;
        reg_thread_i <= th;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        r = reg_rdata_o;
        f = gp_fault_o;
    endtask
    task automatic wr(input logic [11:0] a, input logic [63:0] d, input logic ef);
        logic [63:0] r;
        logic        f;
        acc(1'b1, a, d, r, f);
        chk("write fault", {63'h0, f}, {63'h0, ef});
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] e, input logic ef);
        logic [63:0] r;
        logic        f;
        acc(1'b0, a, 64'h0, r, f);
        chk("read data", r, e);
        chk("read fault", {63'h0, f}, {63'h0, ef});
    endtask
    task automatic fl(input logic [0:0] t, input logic code, input logic [15:0] off, input logic [15:0] e);
        @(posedge mclk_i);
        ways_off_i <= off;
        core.issue(t, code);
        #1;
        chk("fill ways", {47'h0, fill_valid_o, fill_ways_o}, {47'h0, 1'b1, e});
    endtask
    function automatic logic [63:0] cls(input logic [31:0] c);
        return {c, 32'h0000_0000};
    endfunction
    task automatic close_out;
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog sized well above the roughly 170 cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(CF, 64'h0, 1'b0);
        rd(AS, cls(32'h0), 1'b0);
        for (int n = 0; n < NC; n++) rd(MB + 12'(n), 64'hFFFF, 1'b0);
        for (int n = 0; n < NC; n++) begin
            wr(MB + 12'(n), 64'h3 << n, 1'b0);
            rd(MB + 12'(n), 64'h3 << n, 1'b0);
        end
        // Refused accesses must leave state alone
        wr(MB + 12'(NC), 64'hFFFF, 1'b1);
        rd(MB + 12'(NC), 64'h0, 1'b1);
        wr(MB + 12'h001, 64'h1_0000, 1'b1);
        rd(MB + 12'h001, 64'h6, 1'b0);
        wr(CF, 64'h2, 1'b1);
        rd(CF, 64'h0, 1'b0);
        wr(AS, 64'h1, 1'b1);
        wr(AS, cls(32'h10), 1'b1);
        wr(AS, cls(32'hF), 1'b0);
        rd(AS, cls(32'hF), 1'b0);
        wr(12'h000, 64'h0, 1'b1);
        rd(12'h000, 64'h0, 1'b1);
        th = 1'b1;
        wr(AS, cls(32'h3), 1'b0);
        th = 1'b0;
        wr(AS, cls(32'h2), 1'b0);
        rd(AS, cls(32'h2), 1'b0);
        // Shared mode: one mask for code and data; powered-off ways are dropped
        fl(1'b1, 1'b1, 16'h0000, 16'h0018);
        fl(1'b1, 1'b0, 16'h0000, 16'h0018);
        fl(1'b0, 1'b0, 16'h0004, 16'h0008);
        fl(1'b0, 1'b1, 16'h0000, 16'h000C);
        // Idle and management events must not disturb state
        @(posedge mclk_i) {deep_idle_i, pkg_idle_i, smi_i} <= 3'b111;
        repeat (3) @(posedge mclk_i);
        {deep_idle_i, pkg_idle_i, smi_i} <= 3'b000;
        rd(AS, cls(32'h2), 1'b0);
        rd(MB + 12'h007, 64'h180, 1'b0);
        // Handler moves to its own class and back
        wr(AS, cls(32'h7), 1'b0);
        fl(1'b0, 1'b0, 16'h0000, 16'h0180);
        wr(AS, cls(32'h2), 1'b0);
        rd(AS, cls(32'h2), 1'b0);
        // Split mode entry: masks opened and threads parked in class zero first
        for (int n = 0; n < NC; n++) wr(MB + 12'(n), 64'hFFFF, 1'b0);
        wr(AS, cls(32'h0), 1'b0);
        th = 1'b1;
        wr(AS, cls(32'h0), 1'b0);
        wr(CF, 64'h1, 1'b0);
        chk("split enable", {63'h0, split_en_o}, 64'h1);
        for (int n = 0; n < NC; n++) wr(MB + 12'(n), 64'h1 << n, 1'b0);
        wr(AS, cls(32'h2), 1'b0);
        fl(1'b1, 1'b0, 16'h0000, 16'h0010);
        fl(1'b1, 1'b1, 16'h0000, 16'h0020);
        fl(1'b0, 1'b0, 16'h0000, 16'h0001);
        fl(1'b0, 1'b1, 16'h0000, 16'h0002);
        close_out();
    end
endmodule
